// ---- logic/adcrc_pkg.sv ----
// constants, register map and state codes of the converter control block
// Functional notes
// - internal clock, sync not inverted: sync high
// - internal clock, sync inverted: sync low
// - frame sync only with internal serial clock
// - parallel mode: shared pins carry bits 10, 11
// - data bits 12 to 15 outputs in both modes while the bus is enabled
// - slave read unfinished at conversion end: overrun
// - busy high from start until result latched
// - output bus enabled only with select and read, except sync and overrun pins, always driven in serial mode
// - select gates the external serial clock
// - reset input aborts conversion and readout, restarts acquisition
// - power down finishes conversion, then blocks more
// - start high at acquisition end: await fall
// - start low at acquisition end: convert now
// - external clock edge choice set by invert
// - serial result shifted out most significant first
package adcrc_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS   = 40;     // 25 MHz system clock
    localparam int ACQ_TIME_NS     = 1000;   // acquisition phase, least time
    localparam int CONV_TIME_NS    = 8000;   // conversion time, least time
    localparam int SCLK_HALF_NS    = 160;    // half period of generated serial clock
    localparam logic [7:0] ACQ_CYCLES =
        8'((ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] CONV_CYCLES =
        8'((CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [2:0] SCLK_HALF_CYCLES =
        3'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] ACQ_LAST       = ACQ_CYCLES - 8'h01;
    localparam logic [7:0] CONV_LAST      = CONV_CYCLES - 8'h01;
    localparam logic [2:0] SCLK_HALF_LAST = SCLK_HALF_CYCLES - 3'h1;
    localparam logic [1:0] OVR_PULSE_CYCLES = 2'h2;  // overrun pulse width
    localparam logic [3:0] LAST_BIT       = 4'hf;    // sixteenth serial bit
    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_RESULT   = 8'h08;
    localparam logic [7:0] OFS_INT_STAT = 8'h0c;
    localparam logic [7:0] OFS_INT_MASK = 8'h10;
    // control field positions
    localparam int CTRL_SERIAL_PARALLEL_SELECT   = 0;       // serial_parallel_select
    localparam int CTRL_CLK_SRC   = 1;       // clock_source_select, 1 = external
    localparam int CTRL_SYNC_INV  = 2;       // frame_sync_invert
    localparam int CTRL_SCLK_INV  = 3;       // serial_clock_invert
    localparam logic [3:0] CTRL_RESET = 4'h0;
    // interrupt field positions
    localparam int INT_CONV_DONE = 0;
    localparam int INT_OVERRUN   = 1;
    localparam logic [1:0] INT_RESET = 2'h0;
    // pin positions on the shared data bus
    localparam int PIN_SDATA = 8;
    localparam int PIN_SCLK  = 9;
    localparam int PIN_SYNC  = 10;
    localparam int PIN_OVR   = 11;
    // conversion sequencer states
    typedef enum logic [3:0] {
        ST_ACQ  = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_CONV = 4'b0100,
        ST_PD   = 4'b1000
    } adcrc_state_t;
endpackage

// ---- logic/adcrc_top.sv ----
// conversion sequencer, readout pins and apb register slave of the converter
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
module adcrc_top (
    input  wire logic        clk_i,               // 25 MHz system clock
    input  wire logic        rst_b_i,             // synchronous reset, active low
    input  wire logic        ce_i,                // clock enable, freezes state when low
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             irq_o,               // level, unmasked status set
    input  wire logic        conversion_start_n_i,
    input  wire logic        chip_select_n_i,
    input  wire logic        read_n_i,
    input  wire logic        device_reset_i,      // pin reset, active high
    input  wire logic        power_down_i,
    input  wire logic        sclk_i,              // external serial clock pin
    input  wire logic [15:0] sample_i,            // result word from the analog core
    output logic             busy_o,
    output logic      [15:0] data_o,              // shared data and serial pins
    output logic      [15:0] data_oe_o            // high while the pin is driven
);
    // synchroniser stages: cnv, cs, rd, reset, pd, sclk
    logic [5:0] meta_r;                           // first stage, read by sync_r only
    logic [5:0] sync_r;                           // second stage
    logic       cnv_prev_r;                       // start strobe one cycle ago
    logic       sclk_prev_r;                      // serial clock one cycle ago
    logic cnv_s, cs_s, rd_s, dres_s, pd_s, sclk_s;
    assign {sclk_s, pd_s, dres_s, rd_s, cs_s, cnv_s} = sync_r;

    // sequencer and serial state
    adcrc_pkg::adcrc_state_t st_r, st_nxt;
    logic [7:0]  cnt_r, cnt_nxt;                  // phase timer
    logic [15:0] result_r, result_nxt;            // latched result
    logic [15:0] shift_r, shift_nxt;              // output shift register
    logic [3:0]  bit_r, bit_nxt;                  // bits already shifted
    logic        avail_r, avail_nxt;              // unread result present
    logic        rdact_r, rdact_nxt;              // read sequence running
    logic        sclk_r, sclk_nxt;                // generated serial clock
    logic [2:0]  div_r, div_nxt;                  // serial clock divider
    logic [1:0]  ovr_r, ovr_nxt;                  // overrun pulse timer
    logic        busy_nxt;
    logic [15:0] pin_nxt, oe_nxt;
    logic        conv_done, ovr_evt, en, upd_edge, cnv_fall;

    // register file state
    logic [3:0]  ctrl_r, ctrl_nxt;
    logic [1:0]  ist_r, ist_nxt;
    logic [1:0]  imask_r, imask_nxt;
    logic        pready_nxt, pslverr_nxt, irq_nxt;
    logic [31:0] prdata_nxt;
    logic        ser, ext, sinv, cinv;
    assign ser  = ctrl_r[adcrc_pkg::CTRL_SERIAL_PARALLEL_SELECT];
    assign ext  = ctrl_r[adcrc_pkg::CTRL_CLK_SRC];
    assign sinv = ctrl_r[adcrc_pkg::CTRL_SYNC_INV];
    assign cinv = ctrl_r[adcrc_pkg::CTRL_SCLK_INV];

    // pins come from outside the clock domain, so two stages each
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            meta_r      <= 6'h07;   // idle levels: strobes high, reset, pd, clock low
            sync_r      <= 6'h07;   // matching idle, so no false edge or reset follows
            cnv_prev_r  <= 1'b1;
            sclk_prev_r <= 1'b0;
        end else if (ce_i) begin
            meta_r      <= {sclk_i, power_down_i, device_reset_i, read_n_i,
                            chip_select_n_i, conversion_start_n_i};
            sync_r      <= meta_r;
            cnv_prev_r  <= cnv_s;
            sclk_prev_r <= sclk_s;
        end
    end

    // next state of sequencer, serial port and pins
    always_comb begin
        st_nxt     = st_r;
        cnt_nxt    = cnt_r;
        result_nxt = result_r;
        shift_nxt  = shift_r;
        bit_nxt    = bit_r;
        avail_nxt  = avail_r;
        rdact_nxt  = rdact_r;
        sclk_nxt   = sclk_r;
        div_nxt    = div_r;
        ovr_nxt    = (ovr_r != 2'h0) ? ovr_r - 2'h1 : 2'h0;
        conv_done  = 1'b0;
        ovr_evt    = 1'b0;
        en         = ~cs_s & ~rd_s;
        cnv_fall   = cnv_prev_r & ~cnv_s;
        // edge that updates data; swaps with the invert bit
        upd_edge   = cinv ? (sclk_prev_r & ~sclk_s)
                          : (~sclk_prev_r & sclk_s);
        case (st_r)
            adcrc_pkg::ST_ACQ: begin
                cnt_nxt = cnt_r + 8'h01;
                if (cnt_r == adcrc_pkg::ACQ_LAST) begin
                    cnt_nxt = 8'h00;
                    if (pd_s)
                        st_nxt = adcrc_pkg::ST_PD;
                    else if (!cnv_s)
                        st_nxt = adcrc_pkg::ST_CONV;
                    else
                        st_nxt = adcrc_pkg::ST_WAIT;
                end
            end
            adcrc_pkg::ST_WAIT: begin
                // only a fresh falling edge starts, for low jitter
                if (pd_s)
                    st_nxt = adcrc_pkg::ST_PD;
                else if (cnv_fall)
                    st_nxt = adcrc_pkg::ST_CONV;
            end
            adcrc_pkg::ST_CONV: begin
                // power down is ignored here: the running conversion ends
                cnt_nxt = cnt_r + 8'h01;
                if (cnt_r == adcrc_pkg::CONV_LAST) begin
                    cnt_nxt   = 8'h00;
                    conv_done = 1'b1;
                    st_nxt    = adcrc_pkg::ST_ACQ;
                end
            end
            adcrc_pkg::ST_PD: begin
                // no conversion may start while power down stands
                if (!pd_s)
                    st_nxt = adcrc_pkg::ST_ACQ;
            end
            default: begin
                st_nxt  = adcrc_pkg::ST_ACQ;
                cnt_nxt = 8'h00;
            end
        endcase
        // serial shifting
        if (ser && !ext) begin
            // internal clock: generate the clock while selected and read
            if (!rdact_r) begin
                if (en && avail_r) begin
                    rdact_nxt = 1'b1;
                    div_nxt   = 3'h0;
                    sclk_nxt  = 1'b0;
                end
            end else if (!en) begin
                rdact_nxt = 1'b0;
                sclk_nxt  = 1'b0;
            end else if (div_r == adcrc_pkg::SCLK_HALF_LAST) begin
                div_nxt  = 3'h0;
                sclk_nxt = ~sclk_r;
                if (sclk_r) begin
                    // falling edge moves to the next bit
                    shift_nxt = {shift_r[14:0], 1'b0};
                    bit_nxt   = bit_r + 4'h1;
                    if (bit_r == adcrc_pkg::LAST_BIT) begin
                        rdact_nxt = 1'b0;
                        avail_nxt = 1'b0;
                    end
                end
            end else begin
                div_nxt = div_r + 3'h1;
            end
        end else if (ser && ext) begin
            // external clock counts only while select is low
            if (!cs_s && upd_edge && avail_r) begin
                shift_nxt = {shift_r[14:0], 1'b0};
                bit_nxt   = bit_r + 4'h1;
                rdact_nxt = 1'b1;
                if (bit_r == adcrc_pkg::LAST_BIT) begin
                    rdact_nxt = 1'b0;
                    avail_nxt = 1'b0;
                end
            end
        end
        // a new result replaces whatever was being read
        if (conv_done) begin
            if (ser && ext && rdact_r) begin
                ovr_evt = 1'b1;
                ovr_nxt = adcrc_pkg::OVR_PULSE_CYCLES;
            end
            result_nxt = sample_i;
            shift_nxt  = sample_i;
            bit_nxt    = 4'h0;
            avail_nxt  = 1'b1;
            rdact_nxt  = 1'b0;
            sclk_nxt   = 1'b0;
        end
        // pin reset aborts everything in flight
        if (dres_s) begin
            st_nxt    = adcrc_pkg::ST_ACQ;
            cnt_nxt   = 8'h00;
            conv_done = 1'b0;
            ovr_evt   = 1'b0;
            ovr_nxt   = 2'h0;
            bit_nxt   = 4'h0;
            avail_nxt = 1'b0;
            rdact_nxt = 1'b0;
            sclk_nxt  = 1'b0;
        end
        busy_nxt = (st_nxt == adcrc_pkg::ST_CONV);
        // pins: parallel word by default, bus gated by select and read except the serial sync and overrun pins
        pin_nxt = result_r;
        oe_nxt  = en ? 16'hffff : 16'h0000;
        if (ser) begin
            oe_nxt[7:0]                  = 8'h00;
            pin_nxt[adcrc_pkg::PIN_SDATA] = shift_r[15];
            pin_nxt[adcrc_pkg::PIN_SCLK]  = sclk_r;
            oe_nxt[adcrc_pkg::PIN_SCLK]   = en & ~ext;
            // sync exists only with the internal clock
            pin_nxt[adcrc_pkg::PIN_SYNC]  = ~ext & (rdact_r ^ sinv);
            pin_nxt[adcrc_pkg::PIN_OVR]   = ext & (ovr_r != 2'h0);
            oe_nxt[adcrc_pkg::PIN_SYNC]   = 1'b1;
            oe_nxt[adcrc_pkg::PIN_OVR]    = 1'b1;
        end
    end

    // sequencer, serial and pin registers
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_r      <= adcrc_pkg::ST_ACQ;
            cnt_r     <= 8'h00;
            result_r  <= 16'h0000;
            shift_r   <= 16'h0000;
            bit_r     <= 4'h0;
            avail_r   <= 1'b0;
            rdact_r   <= 1'b0;
            sclk_r    <= 1'b0;
            div_r     <= 3'h0;
            ovr_r     <= 2'h0;
            busy_o    <= 1'b0;
            data_o    <= 16'h0000;
            data_oe_o <= 16'h0000;
        end else if (ce_i) begin
            st_r      <= st_nxt;
            cnt_r     <= cnt_nxt;
            result_r  <= result_nxt;
            shift_r   <= shift_nxt;
            bit_r     <= bit_nxt;
            avail_r   <= avail_nxt;
            rdact_r   <= rdact_nxt;
            sclk_r    <= sclk_nxt;
            div_r     <= div_nxt;
            ovr_r     <= ovr_nxt;
            busy_o    <= busy_nxt;
            data_o    <= pin_nxt;
            data_oe_o <= oe_nxt;
        end
    end

    // apb slave: one wait state, writes land on the completing edge
    always_comb begin
        ctrl_nxt    = ctrl_r;
        imask_nxt   = imask_r;
        prdata_nxt  = 32'h0000_0000;
        pslverr_nxt = 1'b0;
        pready_nxt  = psel_i & penable_i & ~pready_o;
        ist_nxt     = ist_r;
        if (pready_nxt) begin
            case (paddr_i)
                adcrc_pkg::OFS_CTRL:     prdata_nxt = {28'h0, ctrl_r};
                adcrc_pkg::OFS_STATUS:   prdata_nxt = {28'h0, rdact_r, avail_r,
                                             st_r == adcrc_pkg::ST_PD, busy_o};
                adcrc_pkg::OFS_RESULT:   prdata_nxt = {16'h0, result_r};
                adcrc_pkg::OFS_INT_STAT: prdata_nxt = {30'h0, ist_r};
                adcrc_pkg::OFS_INT_MASK: prdata_nxt = {30'h0, imask_r};
                default:                 pslverr_nxt = 1'b1;   // unmapped
            endcase
        end
        if (psel_i && penable_i && pready_o && pwrite_i) begin
            case (paddr_i)
                adcrc_pkg::OFS_CTRL:     ctrl_nxt  = pwdata_i[3:0];
                adcrc_pkg::OFS_INT_STAT: ist_nxt   = ist_r & ~pwdata_i[1:0];
                adcrc_pkg::OFS_INT_MASK: imask_nxt = pwdata_i[1:0];
                default:                 ctrl_nxt  = ctrl_r;
            endcase
        end
        // set after clear so a same-cycle event is never lost
        ist_nxt = ist_nxt | {ovr_evt, conv_done};
        irq_nxt = |(ist_nxt & imask_nxt);
    end

    // register file flops
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ctrl_r    <= adcrc_pkg::CTRL_RESET;
            ist_r     <= adcrc_pkg::INT_RESET;
            imask_r   <= adcrc_pkg::INT_RESET;
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            irq_o     <= 1'b0;
        end else if (ce_i) begin
            ctrl_r    <= ctrl_nxt;
            ist_r     <= ist_nxt;
            imask_r   <= imask_nxt;
            prdata_o  <= prdata_nxt;
            pready_o  <= pready_nxt;
            pslverr_o <= pslverr_nxt;
            irq_o     <= irq_nxt;
        end
    end

    // checks; frozen cycles are excluded
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i || !ce_i);

    chk_busy_tracks_conv: assert property (busy_o == (st_r == adcrc_pkg::ST_CONV))
        else $error("busy does not follow the conversion phase");
    chk_sync_high_read: assert property (ser && !ext && !sinv && rdact_r
        |=> data_o[adcrc_pkg::PIN_SYNC])
        else $error("frame sync not high during read");
    chk_sync_low_read: assert property (ser && !ext && sinv && rdact_r
        |=> !data_o[adcrc_pkg::PIN_SYNC])
        else $error("inverted frame sync not low during read");
    chk_sync_ext_quiet: assert property (ser && ext |=> !data_o[adcrc_pkg::PIN_SYNC])
        else $error("frame sync driven with external clock");
    chk_par_shared_bits: assert property (!ser
        |=> data_o[11:10] == $past(result_r[11:10]))
        else $error("shared pins not carrying parallel bits");
    chk_high_bits_out: assert property (en |=> data_oe_o[15:12] == 4'hf)
        else $error("upper data bits not driven");
    chk_bus_gated: assert property (!en |=> data_oe_o[adcrc_pkg::PIN_SDATA] == 1'b0)
        else $error("output bus driven without select and read");
    chk_ovr_pulse: assert property (ovr_evt |=> ovr_r != 2'h0 ##1 ovr_r != 2'h0
        ##1 ovr_r == 2'h0)
        else $error("overrun pulse has wrong length");
    chk_sclk_gated: assert property (ser && ext && cs_s && !conv_done && !dres_s
        |=> $stable(bit_r))
        else $error("external clock counted while deselected");
    chk_reset_abort: assert property (dres_s |=> st_r == adcrc_pkg::ST_ACQ && !busy_o)
        else $error("pin reset did not abort");
    chk_pd_blocks: assert property (st_r == adcrc_pkg::ST_PD |=> st_r != adcrc_pkg::ST_CONV)
        else $error("conversion started in power down");
    chk_start_wait: assert property (st_r == adcrc_pkg::ST_WAIT && !cnv_fall
        |=> st_r != adcrc_pkg::ST_CONV)
        else $error("conversion started without a falling edge");
    chk_start_now: assert property (st_r == adcrc_pkg::ST_ACQ && cnt_r == adcrc_pkg::ACQ_LAST
        && !cnv_s && !pd_s && !dres_s |=> st_r == adcrc_pkg::ST_CONV)
        else $error("held start did not convert at once");
endmodule

// ---- verification/adcrc_host_model.sv ----
// host model: drives select, read strobe and external serial clock
`timescale 1ns/100ps
module adcrc_host_model (
    output logic      cs_n_o,
    output logic      rd_n_o,
    output logic      sclk_o,
    input  wire logic sdata_i
);
    // idle: deselected, clock still outside frames
    initial begin
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        sclk_o = 1'b0;
    end
    // both strobes low open the output bus
    task automatic open_bus(input logic on);
        cs_n_o <= !on;
        rd_n_o <= !on;
    endtask
    // bit taken just before each active edge, data settles after the previous one
    task automatic clock_bits(input logic inv, input int n, output logic [15:0] w);
        w = 16'h0000;
        // offset keeps every clock change and sample off the rising system clock edges
        #15 sclk_o = inv;
        for (int i = 0; i < n; i++) begin
            #150 w = {w[14:0], sdata_i};
            #10 sclk_o = !inv;
            #160 sclk_o = inv;
        end
    endtask
endmodule

// ---- verification/adcrc_tb_top.sv ----
// self-checking bench of the converter control block
`timescale 1ns/100ps
module adcrc_tb_top;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic        start_n = 1'b1;       // start strobe, idle high
    logic        dev_rst = 1'b0;       // pin reset
    logic        pd = 1'b0;            // power down pin
    logic [15:0] sample = 16'h0000;    // word from the analog core
    logic [31:0] prdata_o, rd;
    logic        pready_o, pslverr_o, irq_o, busy_o, err, cs_n, rd_n, sclk, seen;
    logic [15:0] data_o, data_oe_o, w;
    logic [15:0] iw = 16'h0000;        // internal clock word as the host sees it
    logic        ce = 1'b1;            // clock enable of the block
    logic        sck_q = 1'b0;         // serial clock pin one cycle ago
    logic        sd_bus;               // serial data as seen on the released bus
    int          errors = 0, tests_run = 0, cycles = 0, ovr_hits = 0, n0;
    logic [3:0]  ctrl_tab [5] = '{4'h0, 4'h3, 4'hb, 4'h1, 4'h5};
    logic [15:0] smp_tab [5] = '{16'ha5c3, 16'h8001, 16'h7ffe, 16'h1234, 16'hbeef};
    adcrc_top adcrc_top_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .irq_o(irq_o), .conversion_start_n_i(start_n),
        .chip_select_n_i(cs_n), .read_n_i(rd_n), .device_reset_i(dev_rst),
        .power_down_i(pd), .sclk_i(sclk), .sample_i(sample), .busy_o(busy_o),
        .data_o(data_o), .data_oe_o(data_oe_o));
    adcrc_host_model host_inst (.cs_n_o(cs_n), .rd_n_o(rd_n), .sclk_o(sclk),
        .sdata_i(sd_bus));
    // an undriven data pin reads inverted, so a missing enable corrupts the word
    assign sd_bus = data_oe_o[8] ? data_o[8] : !data_o[8];
    always #20 clk_i = !clk_i;
    // hang guard and overrun pulse counter
    always @(posedge clk_i) begin
        cycles++;
        if (data_o[11] === 1'b1 && ctrl_tab[0] === 4'h0) ovr_hits++;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end
    // internal clock readout: host takes a bit on each driven serial clock rise
    always @(posedge clk_i) begin
        sck_q <= data_o[9] & data_oe_o[9];
        if (data_o[9] && data_oe_o[9] && !sck_q) iw <= {iw[14:0], sd_bus};
    end
    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    // one apb transfer, entered just after a rising edge; waits for pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        // no cycle count assumed: only the bench timeout ends a hang
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // start held low, so conversion begins at acquisition end or on the fall
    task automatic convert(input logic [15:0] s);
        int n;
        n = 0;
        sample <= s;
        start_n <= 1'b0;
        while (busy_o !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        start_n <= 1'b1;
        n = 0;
        while (busy_o !== 1'b0 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        check(n == int'(adcrc_pkg::CONV_CYCLES), "busy width");
        @(posedge clk_i);
    endtask
    task automatic give_verdict;
        $display("compares %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        wait_clk(16);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        apb(1'b0, adcrc_pkg::OFS_CTRL, 32'h0);
        check(rd === 32'h0 && err === 1'b0 && busy_o === 1'b0, "reset state");
        apb(1'b0, 8'h20, 32'h0);
        check(err === 1'b1 && rd === 32'h0, "unmapped access");
        $display("test reset done");
        // ordinary readouts: parallel, external clock both edges, frame sync both ways
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, adcrc_pkg::OFS_CTRL, {28'h0, ctrl_tab[i]});
            convert(smp_tab[i]);
            apb(1'b0, adcrc_pkg::OFS_RESULT, 32'h0);
            check(rd === {16'h0, smp_tab[i]}, "result register");
            host_inst.open_bus(1'b1);
            wait_clk(6);
            check(data_o[15:12] === smp_tab[i][15:12] && data_oe_o[15] === 1'b1, "top bits");
            if (ctrl_tab[i][0] === 1'b0) begin
                check(data_o === smp_tab[i] && data_oe_o === 16'hffff, "parallel");
            end else if (ctrl_tab[i][1] === 1'b1) begin
                host_inst.clock_bits(ctrl_tab[i][3], 16, w);
                check(w === smp_tab[i], "serial word");
            end else begin
                check(data_o[10] === !ctrl_tab[i][2], "sync active");
                wait_clk(200);
                check(data_o[10] === ctrl_tab[i][2], "sync idle");
                check(iw === smp_tab[i], "internal serial word");
            end
            host_inst.open_bus(1'b0);
            wait_clk(6);
            check(data_oe_o[9:0] === 10'h0, "bus released");
            $display("test row %0d done", i);
        end
        // start high at acquisition end waits for the falling edge
        apb(1'b1, adcrc_pkg::OFS_CTRL, 32'h3);
        apb(1'b1, adcrc_pkg::OFS_INT_MASK, 32'h0);
        wait_clk(100);
        check(busy_o === 1'b0, "no start without edge");
        convert(16'hc33c);
        check(irq_o === 1'b0, "masked irq");
        host_inst.clock_bits(1'b0, 16, w);
        host_inst.open_bus(1'b1);
        host_inst.clock_bits(1'b0, 16, w);
        check(w === 16'hc33c, "deselected clock ignored");
        host_inst.open_bus(1'b0);
        apb(1'b1, adcrc_pkg::OFS_INT_MASK, 32'h3);
        wait_clk(2);
        check(irq_o === 1'b1, "irq raised");
        apb(1'b1, adcrc_pkg::OFS_INT_STAT, 32'h3);
        wait_clk(2);
        check(irq_o === 1'b0, "irq cleared");
        $display("test edge start and irq done");
        // read left unfinished when the next conversion ends
        convert(16'h0f0f);
        apb(1'b1, adcrc_pkg::OFS_INT_STAT, 32'h1);
        host_inst.open_bus(1'b1);
        host_inst.clock_bits(1'b0, 5, w);
        n0 = ovr_hits;
        convert(16'hf00f);
        wait_clk(8);
        check(ovr_hits - n0 == int'(adcrc_pkg::OVR_PULSE_CYCLES), "overrun pulse");
        check(data_o[11] === 1'b0, "overrun self clears");
        apb(1'b0, adcrc_pkg::OFS_INT_STAT, 32'h0);
        check(rd[1] === 1'b1 && irq_o === 1'b1, "overrun status");
        host_inst.open_bus(1'b0);
        $display("test overrun done");
        // power down blocks conversions; pin reset aborts one
        pd <= 1'b1;
        start_n <= 1'b0;
        seen = 1'b0;
        for (int k = 0; k < 300; k++) begin
            @(posedge clk_i);
            seen = seen | busy_o;
        end
        check(seen === 1'b0, "power down blocks");
        pd <= 1'b0;
        wait_clk(60);
        check(busy_o === 1'b1, "conversion after power up");
        // clock enable low freezes the running conversion, busy included
        ce <= 1'b0;
        seen = 1'b0;
        for (int k = 0; k < 300; k++) begin
            @(posedge clk_i);
            seen = seen | !busy_o;
        end
        check(seen === 1'b0, "frozen by clock enable");
        ce <= 1'b1;
        dev_rst <= 1'b1;
        wait_clk(10);
        check(busy_o === 1'b0, "reset aborts");
        // second reset in mid run: control and pins back to reset values
        rst_b_i <= 1'b0;
        dev_rst <= 1'b0;
        wait_clk(16);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        apb(1'b0, adcrc_pkg::OFS_CTRL, 32'h0);
        check(rd === 32'h0 && data_oe_o === 16'h0000, "second reset");
        $display("test power down and reset done");
        give_verdict();
    end
endmodule
